// File: design/sfc_pkg.sv
// Constants, register map and state types of the synthesizer frequency control.
// Assumes one 125 MHz clock; serial port and reference pins arrive synchronous to it.
// Summary of operation
// - Separate 4-bit up and down leak settings.
// - Reset leaves fractional mode, modulator running.
// - Integer bit set, release clear: fixed divide.
// - Output frequency from R, integer, fraction.
// - Integer word is sixteen bits wide.
// - Fractional word is twenty-four bits wide.
// - Reference ratio from register three bits 13:0.
// - Fraction write in fractional mode arms a hop at 31st falling edge; hop at next reference tick.
// - Integer write in fractional mode only buffered.
// - Integer write in integer mode arms a hop; hop at next reference tick.
// - Power-on reset clears all logic quickly.
// - Strobe bit 0 resets serial registers.
// - Strobe bit 1 resets reference divider, hop state and active divide words.
// - Hardware reset pin holds serial registers.
// - Zero in enable register powers down.
// - Sweep register bit 1 enables sweeper.
package sfc_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_LIMIT_NS = 1_000_000;
  localparam int POR_LIMIT_CYCLES = POR_LIMIT_NS / CLK_PERIOD_NS;
  localparam int LEAK_STEP_NA = 28_700;
  localparam int LEAK_MAX_PERCENT = 25;

  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [5:0] HEAD_LAST = 6'h07;
  localparam logic [5:0] FRAME_MAX = 6'h1f;

  localparam logic [5:0] REG_STROBE = 6'h00;
  localparam logic [5:0] REG_ENABLE = 6'h01;
  localparam logic [5:0] REG_REFDIV = 6'h03;
  localparam logic [5:0] REG_LEAK = 6'h08;
  localparam logic [5:0] REG_INTW = 6'h0f;
  localparam logic [5:0] REG_FRACW = 6'h10;
  localparam logic [5:0] REG_DSMCFG = 6'h12;
  localparam logic [5:0] REG_SWEEP = 6'h14;
  localparam logic [5:0] REG_STATUS = 6'h1f;

  localparam int STB_REGS_BIT = 0;
  localparam int STB_DIG_BIT = 1;
  localparam int ENA_DSM_RUN_BIT = 13;
  localparam int CFG_INT_MODE_BIT = 3;
  localparam int CFG_DSM_MODE_LSB = 8;
  localparam int SWP_ENABLE_BIT = 1;
  localparam int LEAK_UP_LSB = 0;
  localparam int LEAK_DN_LSB = 4;

  localparam logic [15:0] ENABLE_RST = 16'h2000;
  localparam logic [13:0] REFDIV_RST = 14'h0001;
  localparam logic [7:0] LEAK_RST = 8'h00;
  localparam logic [15:0] INTW_RST = 16'h0024;
  localparam logic [23:0] FRACW_RST = 24'h00_0000;
  localparam logic [9:0] DSMCFG_RST = 10'h000;
  localparam logic [7:0] SWEEP_RST = 8'h00;

  typedef enum logic [1:0] {PH_IDLE, PH_HEAD, PH_BODY, PH_DONE} sfc_phase_e;

  typedef struct packed {
    logic sclkQ;
    logic refQ;
    sfc_phase_e phase;
    logic [5:0] bitCnt;
    logic isRead;
    logic [30:0] shiftIn;
    logic [23:0] shiftOut;
    logic sdo;
    logic sdoOe;
    logic [15:0] regEnable;
    logic [13:0] regRefdiv;
    logic [7:0] regLeak;
    logic [15:0] regInt;
    logic [23:0] regFrac;
    logic [9:0] regCfg;
    logic [7:0] regSweep;
    logic [13:0] refCnt;
    logic pfdTick;
    logic hopPending;
    logic hopLoad;
    logic [15:0] actInt;
    logic [23:0] actFrac;
    logic modRun;
    logic intOp;
    logic powerDown;
  } sfc_state_s;

endpackage

// File: design/sfc_frequency_control.sv
// Frequency control of a fractional-N synthesizer: serial register port, hop timing,
// reference divider and resets. Expects serial and reference pins synchronous to clk.
module sfc_frequency_control
  import sfc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hwResetN,
  input wire logic serEnable,
  input wire logic serClk,
  input wire logic serDataIn,
  input wire logic refIn,
  output logic serDataOut,
  output logic serDataOe,
  output logic [15:0] activeIntWord,
  output logic [23:0] activeFracWord,
  output logic hopLoad,
  output logic pfdTick,
  output logic modulatorRun,
  output logic integerOp,
  output logic [3:0] upPumpLeakSetting,
  output logic [3:0] downPumpLeakSetting,
  output logic [15:0] enableCtrl,
  output logic powerDown,
  output logic [1:0] dsmModeSel,
  output logic sweepEnable,
  output logic [7:0] sweepCtrl
);

  sfc_state_s s_r;
  sfc_state_s s_nxt;

  logic sclkRise;
  logic sclkFall;
  logic refRise;
  logic commitWr;
  logic [5:0] wrAddr;
  logic [23:0] wrData;
  logic [6:0] headNext;
  logic digStrobe;

  // Readback of one register; strobes and unmapped addresses read as zero.
  function automatic logic [23:0] readReg(input logic [5:0] addr, input sfc_state_s st);
    logic [23:0] v;
    v = 24'h00_0000;
    unique case (addr)
      REG_ENABLE: v = {8'h00, st.regEnable};
      REG_REFDIV: v = {10'h000, st.regRefdiv};
      REG_LEAK: v = {16'h0000, st.regLeak};
      REG_INTW: v = {8'h00, st.regInt};
      REG_FRACW: v = st.regFrac;
      REG_DSMCFG: v = {14'h0000, st.regCfg};
      REG_SWEEP: v = {16'h0000, st.regSweep};
      REG_STATUS: v = {20'h0_0000, st.hopPending, st.modRun, st.intOp, st.powerDown};
      default: v = 24'h00_0000;
    endcase
    return v;
  endfunction

  assign sclkRise = serClk & ~s_r.sclkQ;
  assign sclkFall = ~serClk & s_r.sclkQ;
  assign refRise = refIn & ~s_r.refQ;
  assign headNext = {s_r.shiftIn[5:0], serDataIn};
  // A write commits on the falling edge of the 31st serial clock.
  assign commitWr = sclkFall && serEnable && (s_r.phase == PH_BODY) && (s_r.bitCnt == FRAME_LAST)
    && !s_r.isRead;
  assign wrAddr = s_r.shiftIn[29:24];
  assign wrData = s_r.shiftIn[23:0];
  assign digStrobe = commitWr && wrAddr == REG_STROBE && wrData[STB_DIG_BIT];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclkQ = serClk;
    s_nxt.refQ = refIn;
    s_nxt.pfdTick = 1'b0;
    s_nxt.hopLoad = 1'b0;

    // Serial port framing.
    if (!serEnable)
    begin
      s_nxt.phase = PH_IDLE;
      s_nxt.bitCnt = 6'h00;
      s_nxt.isRead = 1'b0;
      s_nxt.sdoOe = 1'b0;
      s_nxt.sdo = 1'b0;
    end
    else
    begin
      unique case (s_r.phase)
        PH_IDLE:
        begin
          s_nxt.phase = PH_HEAD;
          s_nxt.bitCnt = 6'h00;
        end
        PH_HEAD:
        begin
          if (sclkRise)
          begin
            s_nxt.shiftIn = {s_r.shiftIn[29:0], serDataIn};
            s_nxt.bitCnt = s_r.bitCnt + 6'h01;
            if (s_r.bitCnt + 6'h01 == HEAD_LAST)
            begin
              s_nxt.phase = PH_BODY;
              s_nxt.isRead = headNext[6];
              s_nxt.shiftOut = readReg(headNext[5:0], s_r);
            end
          end
        end
        PH_BODY:
        begin
          if (sclkRise && s_r.bitCnt != FRAME_MAX)
          begin
            s_nxt.shiftIn = {s_r.shiftIn[29:0], serDataIn};
            s_nxt.bitCnt = s_r.bitCnt + 6'h01;
          end
          if (sclkFall && s_r.isRead)
          begin
            if (s_r.bitCnt < FRAME_LAST)
            begin
              s_nxt.sdo = s_r.shiftOut[23];
              s_nxt.shiftOut = {s_r.shiftOut[22:0], 1'b0};
              s_nxt.sdoOe = 1'b1;
            end
            else
            begin
              s_nxt.sdoOe = 1'b0;
              s_nxt.phase = PH_DONE;
            end
          end
          if (commitWr)
          begin
            s_nxt.phase = PH_DONE;
          end
        end
        PH_DONE:
        begin
          s_nxt.phase = PH_DONE;
        end
      endcase
    end

    // Reference divider: one tick per R reference edges; zero or one divides by one.
    if (refRise)
    begin
      if (s_r.refCnt + 14'h0001 >= s_r.regRefdiv)
      begin
        s_nxt.refCnt = 14'h0000;
        s_nxt.pfdTick = 1'b1;
      end
      else
      begin
        s_nxt.refCnt = s_r.refCnt + 14'h0001;
      end
    end

    // The integer word and, in fractional mode, the fraction word move on the same tick; integer mode loads a zero fraction.
    if (s_nxt.pfdTick && s_r.hopPending)
    begin
      s_nxt.actInt = s_r.regInt;
      s_nxt.actFrac = s_r.regCfg[CFG_INT_MODE_BIT] ? 24'h00_0000 : s_r.regFrac;
      s_nxt.hopPending = 1'b0;
      s_nxt.hopLoad = 1'b1;
    end

    // Register writes; a hop trigger here re-arms the hop that a transfer in the same cycle clears.
    if (commitWr)
    begin
      unique case (wrAddr)
        REG_ENABLE: s_nxt.regEnable = wrData[15:0];
        REG_REFDIV: s_nxt.regRefdiv = wrData[13:0];
        REG_LEAK: s_nxt.regLeak = wrData[7:0];
        REG_DSMCFG: s_nxt.regCfg = wrData[9:0];
        REG_SWEEP: s_nxt.regSweep = wrData[7:0];
        REG_INTW:
        begin
          s_nxt.regInt = wrData[15:0];
          if (s_r.regCfg[CFG_INT_MODE_BIT])
          begin
            s_nxt.hopPending = 1'b1;
          end
        end
        REG_FRACW:
        begin
          s_nxt.regFrac = wrData;
          if (!s_r.regCfg[CFG_INT_MODE_BIT])
          begin
            s_nxt.hopPending = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Digital reset strobe: reference counter, hop state and active divide words; serial registers and port framing are kept.
    if (digStrobe)
    begin
      s_nxt.refCnt = 14'h0000;
      s_nxt.pfdTick = 1'b0;
      s_nxt.hopPending = 1'b0;
      s_nxt.hopLoad = 1'b0;
      s_nxt.actInt = INTW_RST;
      s_nxt.actFrac = FRACW_RST;
    end

    // Register reset by strobe or by the hardware pin; strobes are never stored.
    if (!hwResetN || (commitWr && wrAddr == REG_STROBE && wrData[STB_REGS_BIT]))
    begin
      s_nxt.regEnable = ENABLE_RST;
      s_nxt.regRefdiv = REFDIV_RST;
      s_nxt.regLeak = LEAK_RST;
      s_nxt.regInt = INTW_RST;
      s_nxt.regFrac = FRACW_RST;
      s_nxt.regCfg = DSMCFG_RST;
      s_nxt.regSweep = SWEEP_RST;
    end

    s_nxt.intOp = s_nxt.regCfg[CFG_INT_MODE_BIT];
    s_nxt.modRun = !s_nxt.regCfg[CFG_INT_MODE_BIT] && s_nxt.regEnable[ENA_DSM_RUN_BIT];
    s_nxt.powerDown = (s_nxt.regEnable == 16'h0000);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.phase <= PH_IDLE;
      s_r.regEnable <= ENABLE_RST;
      s_r.regRefdiv <= REFDIV_RST;
      s_r.regLeak <= LEAK_RST;
      s_r.regInt <= INTW_RST;
      s_r.regFrac <= FRACW_RST;
      s_r.regCfg <= DSMCFG_RST;
      s_r.regSweep <= SWEEP_RST;
      s_r.actInt <= INTW_RST;
      s_r.actFrac <= FRACW_RST;
      s_r.modRun <= ENABLE_RST[ENA_DSM_RUN_BIT];
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign serDataOut = s_r.sdo;
  assign serDataOe = s_r.sdoOe;
  assign activeIntWord = s_r.actInt;
  assign activeFracWord = s_r.actFrac;
  assign hopLoad = s_r.hopLoad;
  assign pfdTick = s_r.pfdTick;
  assign modulatorRun = s_r.modRun;
  assign integerOp = s_r.intOp;
  assign upPumpLeakSetting = s_r.regLeak[LEAK_UP_LSB +: 4];
  assign downPumpLeakSetting = s_r.regLeak[LEAK_DN_LSB +: 4];
  assign enableCtrl = s_r.regEnable;
  assign powerDown = s_r.powerDown;
  assign dsmModeSel = s_r.regCfg[CFG_DSM_MODE_LSB +: 2];
  assign sweepEnable = s_r.regSweep[SWP_ENABLE_BIT];
  assign sweepCtrl = s_r.regSweep;

  a_reset_fractional: assert property (@(posedge clk) !rstn |=> !integerOp && modulatorRun)
    else $error("Reset did not leave fractional operation.");

  a_integer_stops_mod: assert property (@(posedge clk) disable iff (!rstn) integerOp |-> !modulatorRun)
    else $error("Modulator running in integer operation.");

  a_frac_write_hops: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_FRACW && !integerOp && hwResetN |=> s_r.hopPending)
    else $error("Fractional word write did not arm a hop.");

  a_int_write_buffered: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_INTW && !integerOp && !s_r.hopPending |=> !s_r.hopPending && !hopLoad)
    else $error("Integer word write hopped in fractional operation.");

  a_int_write_hops: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_INTW && integerOp && hwResetN |=> s_r.hopPending)
    else $error("Integer word write did not arm a hop in integer operation.");

  a_hop_on_tick: assert property (@(posedge clk) disable iff (!rstn)
    hopLoad |-> pfdTick && activeIntWord == $past(s_r.regInt) && $past(s_r.hopPending))
    else $error("Divide words moved outside a reference tick or mixed.");

  a_regs_strobe: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_STROBE && wrData[STB_REGS_BIT]
    |=> s_r.regInt == INTW_RST && enableCtrl == ENABLE_RST && s_r.regRefdiv == REFDIV_RST)
    else $error("Register reset strobe left a register changed.");

  a_digital_strobe: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_STROBE && wrData == 24'h00_0002 && hwResetN
    |=> !s_r.hopPending && s_r.refCnt == 14'h0000 && enableCtrl == $past(enableCtrl))
    else $error("Digital reset strobe misbehaved.");

  a_hw_reset_regs: assert property (@(posedge clk) disable iff (!rstn)
    !hwResetN |=> s_r.regRefdiv == REFDIV_RST && s_r.regLeak == LEAK_RST && s_r.regFrac == FRACW_RST)
    else $error("Hardware reset did not hold the registers.");

  a_power_down: assert property (@(posedge clk) disable iff (!rstn)
    powerDown == (enableCtrl == 16'h0000))
    else $error("Power-down flag disagrees with enable register.");

  a_frac_hop_words: assert property (@(posedge clk) disable iff (!rstn)
    hopLoad && !$past(integerOp) |-> activeFracWord == $past(s_r.regFrac))
    else $error("Fractional word loaded differs from the stored one.");

  a_int_hop_nofrac: assert property (@(posedge clk) disable iff (!rstn)
    hopLoad && $past(integerOp) |-> activeFracWord == 24'h00_0000)
    else $error("Fraction used in integer operation.");

  a_words_hold: assert property (@(posedge clk) disable iff (!rstn)
    !hopLoad && !$past(digStrobe) |-> $stable(activeIntWord) && $stable(activeFracWord))
    else $error("Divide words changed without a load.");

  a_tick_one_ratio: assert property (@(posedge clk) disable iff (!rstn)
    refRise && s_r.regRefdiv <= 14'h0001 && !digStrobe |=> pfdTick)
    else $error("Divide by one missed a reference edge.");

  a_tick_from_ref: assert property (@(posedge clk) disable iff (!rstn)
    pfdTick |-> $past(refRise))
    else $error("Reference tick without a reference edge.");

  a_strobe_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
    serEnable && sclkRise && s_r.phase == PH_HEAD && s_r.bitCnt + 6'h01 == HEAD_LAST
    && headNext == {1'b1, REG_STROBE} |=> s_r.shiftOut == 24'h00_0000)
    else $error("Strobe register read back nonzero.");

  a_leak_write: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_LEAK && hwResetN
    |=> upPumpLeakSetting == $past(wrData[3:0]) && downPumpLeakSetting == $past(wrData[7:4]))
    else $error("Leak settings differ from the written value.");

  a_refdiv_write: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_REFDIV && hwResetN |=> s_r.regRefdiv == $past(wrData[13:0]))
    else $error("Reference ratio differs from the written value.");

  a_sweep_write: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_SWEEP && hwResetN |=> sweepEnable == $past(wrData[SWP_ENABLE_BIT]))
    else $error("Sweep enable differs from the written bit.");

  a_enable_write: assert property (@(posedge clk) disable iff (!rstn)
    commitWr && wrAddr == REG_ENABLE && hwResetN |=> enableCtrl == $past(wrData[15:0]))
    else $error("Enable register differs from the written value.");

endmodule

// File: dv/sfc_host_model.sv
// Host controller model that writes and reads registers over the serial port.
// Assumes serial pins are sampled by the block on clk; each serial clock phase lasts 3 clk cycles.
module sfc_host_model (
  input wire logic clk,
  output logic serEnable,
  output logic serClk,
  output logic serDataIn,
  input wire logic serDataOut
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    serEnable = 1'b0;
    serClk = 1'b0;
    serDataIn = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Read data is taken just before each rising serial clock that follows the address.
  task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] wdata, output logic [23:0] rdata);
    logic [30:0] bits;
    bits = {rd, addr, wdata};
    rdata = '0;
    serEnable = 1'b1;
    tick(3);
    for (int i = 30; i >= 0; i--)
    begin
      serDataIn = bits[i];
      tick(3);
      if (i < 24)
        rdata = {rdata[22:0], serDataOut};
      serClk = 1'b1;
      tick(3);
      serClk = 1'b0;
    end
    tick(3);
    serEnable = 1'b0;
    // A released data line must not keep showing the last bit.
    serDataIn = ~serDataIn;
    tick(3);
  endtask
endmodule

// File: dv/synth_frequency_control_bench.sv
// Self-checking bench of the synthesizer frequency control.
// Assumes the design package and the host model driving the serial pins.
module synth_frequency_control_bench
  import sfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hwResetN = 1'b1;
  logic refIn = 1'b0;
  logic serEnable, serClk, serDataIn, serDataOut, serDataOe, hopLoad, pfdTick, modulatorRun, integerOp;
  logic powerDown, sweepEnable, hopTick;
  logic oeSeen = 1'b0;
  logic [15:0] activeIntWord, enableCtrl, hopInt;
  logic [23:0] activeFracWord, rdv, hopFrac, saved;
  logic [3:0] upLeak, dnLeak;
  logic [1:0] dsmModeSel;
  logic [7:0] sweepCtrl;
  int errCount = 0;
  int numChecks = 0;
  int cycles = 0;
  int hops = 0;
  int gap;
  int n0;

  always #4 clk = ~clk;

  always
  begin
    repeat (2) @(posedge clk);
    #1 refIn = ~refIn;
  end

  sfc_frequency_control u_dut (.clk(clk), .rstn(rstn), .hwResetN(hwResetN), .serEnable(serEnable),
    .serClk(serClk), .serDataIn(serDataIn), .refIn(refIn), .serDataOut(serDataOut), .serDataOe(serDataOe),
    .activeIntWord(activeIntWord), .activeFracWord(activeFracWord), .hopLoad(hopLoad), .pfdTick(pfdTick),
    .modulatorRun(modulatorRun), .integerOp(integerOp), .upPumpLeakSetting(upLeak),
    .downPumpLeakSetting(dnLeak), .enableCtrl(enableCtrl), .powerDown(powerDown), .dsmModeSel(dsmModeSel),
    .sweepEnable(sweepEnable), .sweepCtrl(sweepCtrl));

  sfc_host_model u_host (.clk(clk), .serEnable(serEnable), .serClk(serClk), .serDataIn(serDataIn),
    .serDataOut(serDataOut));

  // Records the words and tick of each load pulse at the falling edge, where the outputs have settled.
  always @(negedge clk)
  begin
    cycles++;
    if (serDataOe === 1'b1)
      oeSeen = 1'b1;
    if (hopLoad === 1'b1)
    begin
      hops++;
      hopTick = pfdTick;
      hopInt = activeIntWord;
      hopFrac = activeFracWord;
    end
    if (cycles == 30000)
    begin
      errCount++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_host.frame(1'b0, a, d, rdv);
    tick(2);
  endtask

  task automatic rd(input logic [5:0] a);
    u_host.frame(1'b1, a, 24'h00_0000, rdv);
  endtask

  task automatic await_hop();
    for (int i = 0; i < 100 && hops == n0; i++)
      tick(1);
  endtask

  // Measures the clk cycles between two divided reference ticks.
  task automatic pfd_gap();
    repeat (2)
    begin
      gap = 0;
      do
      begin
        tick(1);
        gap++;
      end
      while (pfdTick !== 1'b1 && gap < 200);
    end
  endtask

  task automatic t_reset();
    check(enableCtrl, ENABLE_RST);
    check({modulatorRun, integerOp, powerDown}, 3'b100);
    check(activeIntWord, INTW_RST);
    check(activeFracWord, FRACW_RST);
    check(serDataOe, 1'b0);
    oeSeen = 1'b0;
    rd(REG_ENABLE);
    check(rdv, 24'(ENABLE_RST));
    check({oeSeen, serDataOe}, 2'b10);
    pfd_gap();
    check(24'(gap), 24'h00_0004);
  endtask

  task automatic t_leak_refdiv();
    oeSeen = 1'b0;
    wr(REG_LEAK, 24'h00_00a5);
    check({upLeak, dnLeak}, 8'h5a);
    check(oeSeen, 1'b0);
    wr(REG_REFDIV, 24'hff_c003);
    rd(REG_REFDIV);
    check(rdv, 24'h00_0003);
    pfd_gap();
    check(24'(gap), 24'h00_000c);
  endtask

  task automatic t_frac_hop();
    n0 = hops;
    wr(REG_INTW, 24'h00_005c);
    tick(40);
    check({24'(hops - n0)}, 24'h00_0000);
    check(activeIntWord, INTW_RST);
    wr(REG_FRACW, 24'h00_20c5);
    await_hop();
    check(24'(hops - n0), 24'h00_0001);
    check({hopTick, hopInt}, {1'b1, 16'h005c});
    check(hopFrac, 24'h00_20c5);
  endtask

  task automatic t_int_hop();
    wr(REG_DSMCFG, 24'h00_0308);
    wr(REG_ENABLE, 24'h00_0001);
    check({integerOp, modulatorRun, dsmModeSel}, 4'hb);
    n0 = hops;
    wr(REG_FRACW, 24'h00_1234);
    tick(40);
    check(24'(hops - n0), 24'h00_0000);
    wr(REG_INTW, 24'h00_0030);
    await_hop();
    check(24'(hops - n0), 24'h00_0001);
    check({hopInt, hopFrac[7:0]}, 24'h00_3000);
    wr(REG_DSMCFG, 24'h00_0000);
    wr(REG_ENABLE, 24'h00_2000);
    check({integerOp, modulatorRun}, 2'b01);
  endtask

  task automatic t_power_sweep();
    rd(REG_ENABLE);
    saved = rdv;
    wr(REG_ENABLE, 24'h00_0000);
    check(powerDown, 1'b1);
    wr(REG_ENABLE, saved);
    check({powerDown, enableCtrl}, {1'b0, saved[15:0]});
    wr(REG_SWEEP, 24'h00_0002);
    check({sweepEnable, sweepCtrl}, 9'h102);
  endtask

  task automatic t_resets();
    wr(REG_STROBE, 24'h00_0002);
    check(activeIntWord, INTW_RST);
    check(sweepEnable, 1'b1);
    rd(REG_STROBE);
    check(rdv, 24'h00_0000);
    wr(REG_STROBE, 24'h00_0001);
    check({sweepEnable, upLeak, enableCtrl}, {1'b0, LEAK_RST[3:0], ENABLE_RST});
    wr(REG_LEAK, 24'h00_0033);
    hwResetN = 1'b0;
    tick(3);
    check({upLeak, dnLeak}, 8'h00);
    hwResetN = 1'b1;
    tick(1);
    check({upLeak, dnLeak}, 8'h00);
  endtask

  initial
  begin
    tick(8);
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_leak_refdiv();
    t_frac_hop();
    t_int_hop();
    t_power_sweep();
    t_resets();
    stop_test();
  end
endmodule
